/* common/seg_display_params.svh */
// Offsets, field positions, reset values and timing counts of the display block.
`ifndef SEG_DISPLAY_PARAMS_SVH
`define SEG_DISPLAY_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_VALUE1 8'h04
`define REG_VALUE2 8'h08
`define REG_SEG_SRC 8'h0c
`define REG_SEG_DST 8'h10
`define REG_STATUS 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_MODE_LSB 1
`define STATUS_ERROR_BIT 0
`define STATUS_DONE_BIT 1
`define STATUS_DIGIT_LSB 2
`define STATUS_PHASE_LSB 4

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define CTRL_RESET 4'h0
`define VALUE_RESET 16'h0000
`define SEG_RESET 16'h0000
`define BCD_MAX_VALUE 16'h270f
`define LAST_DIGIT 2'h3

// ----------------------------------------------------------------------------
// Timing: one scan step is fixed at 10 ms of a 125 MHz clock
// ----------------------------------------------------------------------------
`define CLK_FREQ_HZ 125000000
`define SCAN_STEP_MS 10
`define SCAN_STEP_CYCLES (`CLK_FREQ_HZ / 1000 * `SCAN_STEP_MS)

`endif

/* common/seg_display_pkg.sv */
// Types shared by the display driver and its register port.
package seg_display_pkg;

    // ------------------------------------------------------------------------
    // Scan phase of one digit, one-hot coded.
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_DATA = 3'b001,
        PH_STROBE = 3'b010,
        PH_RELEASE = 3'b100
    } phase_type;

    // Software control word: mode (group count and polarity) and enable.
    typedef struct packed {
        logic [2:0] mode;
        logic enable;
    } ctrl_type;

    // The twelve consecutive display outputs, base output 0 in the low bit.
    typedef struct packed {
        logic [3:0] group2;
        logic [3:0] strobe;
        logic [3:0] group1;
    } display_out_type;

endpackage

/* rtl/hex_to_segment_decoder.sv */
// Combinational hex nibble to seven-segment pattern decoder.
`timescale 1ns/10ps

module hex_to_segment_decoder
    import seg_display_pkg::*;
(
    input wire logic [15:0] src_word,
    output logic [7:0] pattern
);

    // ------------------------------------------------------------------------
    // Lookup: bit 0 is segment a up to bit 6 segment g, set means lit.
    // ------------------------------------------------------------------------
    always_comb
    begin
        // Only the low nibble is looked at; upper source bits are ignored.
        case (src_word[3:0])
            4'h0: pattern = 8'h3f;
            4'h1: pattern = 8'h06;
            4'h2: pattern = 8'h5b;
            4'h3: pattern = 8'h4f;
            4'h4: pattern = 8'h66;
            4'h5: pattern = 8'h6d;
            4'h6: pattern = 8'h7d;
            4'h7: pattern = 8'h07;
            4'h8: pattern = 8'h7f;
            4'h9: pattern = 8'h6f;
            4'ha: pattern = 8'h77;
            4'hb: pattern = 8'h7c;
            4'hc: pattern = 8'h39;
            4'hd: pattern = 8'h5e;
            4'he: pattern = 8'h79;
            4'hf: pattern = 8'h71;
            // Bit 7 has no segment, so every entry keeps it at zero.
            default: pattern = 8'h00;
        endcase
    end

endmodule

/* rtl/multiplexed_bcd_display_driver.sv */
// Multiplexed BCD display driver with a hex segment decoder and register port.
//
// Behaviour
// - Decoder uses only the low source nibble.
// - Decoder writes low byte, keeps high byte.
// - Pattern bit 0 is segment a to g.
// - Digits 0 to 9 give fixed patterns.
// - Digits A to F give fixed patterns.
// - Eight outputs, or twelve for two groups.
// - Mode 0-3 one group, 4-7 two groups.
// - Values converted to four BCD digits each.
// - Displayed value above 9999 flags an operation error while enabled.
// - Group one on outputs 0-3, strobes 4-7.
// - Group two on outputs 8-11, shared strobes.
// - Rotation repeats, twelve scan steps each.
// - Completion flag high one step per rotation.
// - Each scan step fixed at 10 ms.
// - Positive data: output equals digit bit.
// - Negative data: output is complemented bit.
// - Mode low bits select data and strobe polarity.
// - Negative strobe is low while latching.
`timescale 1ns/10ps
`include "seg_display_params.svh"

module multiplexed_bcd_display_driver
    import seg_display_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `SCAN_STEP_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output display_out_type disp_out,
    output logic cycle_complete_flag,
    output logic operation_error
);

    // ------------------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------------------
    ctrl_type ctrl_q, ctrl_d; // Enable and mode.
    logic [15:0] value1_q, value1_d; // Word shown on group one.
    logic [15:0] value2_q, value2_d; // Word shown on group two.
    logic [15:0] src_q, src_d; // Last word given to the decoder.
    logic [15:0] dst_q, dst_d; // Decoder destination word.
    logic err_q, err_d; // Sticky operation error.
    logic [31:0] rdata_q, rdata_d; // Read data, valid one cycle after strobe.
    logic [7:0] seg_pattern; // Decoder output for the write data.
    logic err_set; // An out-of-range value is being displayed.
    logic two_groups; // Mode asks for the second group.

    // ------------------------------------------------------------------------
    // Scan state
    // ------------------------------------------------------------------------
    phase_type phase_q, phase_d; // Step within the current digit.
    logic [1:0] digit_q, digit_d; // Digit index, 0 is the units digit.
    logic [20:0] cnt_q, cnt_d; // Cycles within the current scan step.
    logic done_q, done_d; // Completion flag.
    display_out_type disp_q, disp_d; // Registered output pins.
    logic tick; // Last cycle of a scan step.
    logic [15:0] bcd1, bcd2; // Converted group values.
    logic [3:0] digit1, digit2; // Digits selected for the next state.

    // ------------------------------------------------------------------------
    // Binary to four BCD digits by shift and add-three.
    // ------------------------------------------------------------------------
    function automatic logic [15:0] to_bcd(input logic [15:0] bin);
        logic [31:0] sh;
        sh = {16'h0000, bin};
        for (int i = 0; i < 16; i++)
        begin
            for (int j = 0; j < 4; j++)
            begin
                if (sh[16 + 4 * j +: 4] >= 4'h5)
                begin
                    sh[16 + 4 * j +: 4] = sh[16 + 4 * j +: 4] + 4'h3;
                end
            end
            sh = {sh[30:0], 1'b0};
        end
        return sh[31:16];
    endfunction

    // Decoder works straight off the write data so a write lands in one cycle.
    hex_to_segment_decoder decoder_inst
    (
        .src_word(reg_wdata[15:0]),
        .pattern(seg_pattern)
    );

    assign two_groups = ctrl_q.mode[2];
    assign bcd1 = to_bcd(value1_q);
    assign bcd2 = to_bcd(value2_q);
    // Only values that are actually on the display can raise the error.
    assign err_set = ctrl_q.enable && ((value1_q > `BCD_MAX_VALUE)
        || (two_groups && (value2_q > `BCD_MAX_VALUE)));

    // ------------------------------------------------------------------------
    // Register writes, error flag and read mux.
    // ------------------------------------------------------------------------
    always_comb
    begin
        ctrl_d = ctrl_q;
        value1_d = value1_q;
        value2_d = value2_q;
        src_d = src_q;
        dst_d = dst_q;
        rdata_d = 32'h0000_0000;
        // Error write-one-to-clear; a new error in the same cycle wins.
        err_d = err_q;
        if (reg_wr && (reg_addr == `REG_STATUS) && reg_wdata[`STATUS_ERROR_BIT])
        begin
            err_d = 1'b0;
        end
        if (err_set)
        begin
            err_d = 1'b1;
        end
        if (reg_wr)
        begin
            case (reg_addr)
                `REG_CTRL: ctrl_d = reg_wdata[3:0];
                `REG_VALUE1: value1_d = reg_wdata[15:0];
                `REG_VALUE2: value2_d = reg_wdata[15:0];
                `REG_SEG_SRC:
                begin
                    src_d = reg_wdata[15:0];
                    // The high byte of the destination is left untouched.
                    dst_d = {dst_q[15:8], seg_pattern};
                end
                `REG_SEG_DST: dst_d = reg_wdata[15:0];
                default: ; // Unmapped writes are ignored.
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `REG_CTRL: rdata_d = {28'h0000000, ctrl_q};
                `REG_VALUE1: rdata_d = {16'h0000, value1_q};
                `REG_VALUE2: rdata_d = {16'h0000, value2_q};
                `REG_SEG_SRC: rdata_d = {16'h0000, src_q};
                `REG_SEG_DST: rdata_d = {16'h0000, dst_q};
                `REG_STATUS: rdata_d = {25'h0000000, phase_q, digit_q, done_q, err_q};
                default: rdata_d = 32'h0000_0000; // Unmapped reads return zero.
            endcase
        end
    end

    // Register bank; synchronous reset.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ctrl_q <= `CTRL_RESET;
            value1_q <= `VALUE_RESET;
            value2_q <= `VALUE_RESET;
            src_q <= `SEG_RESET;
            dst_q <= `SEG_RESET;
            err_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            value1_q <= value1_d;
            value2_q <= value2_d;
            src_q <= src_d;
            dst_q <= dst_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // Scan sequencer: three steps per digit, four digits, then repeat.
    // ------------------------------------------------------------------------
    assign tick = (cnt_q == 21'(STEP_CYCLES - 1));

    always_comb
    begin
        cnt_d = 21'h000000;
        phase_d = PH_DATA;
        digit_d = 2'h0;
        done_d = 1'b0;
        // Disabled: hold at the first digit so the next enable restarts.
        if (ctrl_q.enable)
        begin
            cnt_d = tick ? 21'h000000 : cnt_q + 21'h000001;
            phase_d = phase_q;
            digit_d = digit_q;
            done_d = tick ? 1'b0 : done_q;
            if (tick)
            begin
                case (phase_q)
                    PH_DATA: phase_d = PH_STROBE;
                    PH_STROBE: phase_d = PH_RELEASE;
                    PH_RELEASE:
                    begin
                        phase_d = PH_DATA;
                        digit_d = digit_q + 2'h1;
                        // The flag spans exactly the step after the last release.
                        done_d = (digit_q == `LAST_DIGIT);
                    end
                    default: phase_d = PH_DATA;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output pins follow the next scan state so they change with it.
    // ------------------------------------------------------------------------
    always_comb
    begin
        digit1 = bcd1[{digit_d, 2'b00} +: 4];
        digit2 = bcd2[{digit_d, 2'b00} +: 4];
        // Idle strobes sit at their inactive level, data at zero.
        disp_d.group1 = 4'h0;
        disp_d.group2 = 4'h0;
        disp_d.strobe = ctrl_q.mode[0] ? 4'hf : 4'h0;
        if (ctrl_q.enable)
        begin
            // Mode bit 1 picks negative data, bit 0 negative strobe.
            disp_d.group1 = ctrl_q.mode[1] ? ~digit1 : digit1;
            if (two_groups)
            begin
                disp_d.group2 = ctrl_q.mode[1] ? ~digit2 : digit2;
            end
            if (phase_d == PH_STROBE)
            begin
                // One strobe at a time latches that digit in both groups.
                disp_d.strobe[digit_d] = ~ctrl_q.mode[0];
            end
        end
    end

    // Sequencer and pin registers.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cnt_q <= 21'h000000;
            phase_q <= PH_DATA;
            digit_q <= 2'h0;
            done_q <= 1'b0;
            disp_q <= 12'h000;
        end
        else
        begin
            cnt_q <= cnt_d;
            phase_q <= phase_d;
            digit_q <= digit_d;
            done_q <= done_d;
            disp_q <= disp_d;
        end
    end

    // Outputs used: eight pins in one-group mode, twelve in two-group mode.
    assign disp_out = disp_q;
    assign cycle_complete_flag = done_q;
    assign operation_error = err_q;
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence last_step_s;
        ctrl_q.enable && tick && (phase_q == PH_RELEASE) && (digit_q == `LAST_DIGIT);
    endsequence

    sequence src_write_s;
        reg_wr && (reg_addr == `REG_SEG_SRC);
    endsequence

    pattern_bit7_a: assert property (seg_pattern[7] == 1'b0)
        else $error("Segment pattern bit 7 is set.");
    high_byte_kept_a: assert property (src_write_s |=> dst_q[15:8] == $past(dst_q[15:8]))
        else $error("Decoder write changed the destination high byte.");
    digit_eight_a: assert property (src_write_s ##0 (reg_wdata[7:0] == 8'hf8)
        |=> dst_q[7:0] == 8'h7f)
        else $error("Digit eight with high bits set decoded wrongly.");
    hex_a_pattern_a: assert property (src_write_s ##0 (reg_wdata[3:0] == 4'ha)
        |=> dst_q[7:0] == 8'h77)
        else $error("Hex digit A decoded wrongly.");
    // The rise and the hold are split so that neither needs an open-ended wait.
    done_pulse_a: assert property (last_step_s |=> done_q)
        else $error("Completion flag missing after a full rotation.");
    done_hold_a: assert property (done_q && ctrl_q.enable && !tick |=> done_q)
        else $error("Completion flag dropped inside its scan step.");
    done_drop_a: assert property (done_q && tick |=> !done_q)
        else $error("Completion flag held longer than one step.");
    // The idle level follows the mode that was current when the pins were computed.
    strobe_idle_a: assert property (!ctrl_q.enable |=>
        disp_q.strobe == {4{$past(ctrl_q.mode[0])}})
        else $error("Strobes not idle while disabled.");
    error_raise_a: assert property (ctrl_q.enable && (value1_q > `BCD_MAX_VALUE)
        |=> err_q)
        else $error("Out of range value did not raise the error.");
    strobe_phase_a: assert property (ctrl_q.enable && !ctrl_q.mode[0]
        && (phase_q == PH_DATA) && !tick |-> disp_q.strobe == 4'h0)
        else $error("Strobe active during a data step.");

endmodule

/* test/display_latch_model.sv */
// Behavioural model of one external latched BCD display group of four digits.
`timescale 1ns/10ps

module display_latch_model
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] data_nib,
    input wire logic [3:0] strobe,
    input wire logic data_neg,
    input wire logic strobe_neg,
    output logic [15:0] shown_q
);
    // ----------------------------------------
    // Digit latches
    // ----------------------------------------
    // A digit captures the data lines only while its own strobe is active.
    // Polarity is undone here, so a wrong polarity shows up as a wrong digit.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            shown_q <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (strobe[i] ^ strobe_neg)
                begin
                    shown_q[i*4 +: 4] <= data_nib ^ {4{data_neg}};
                end
            end
        end
    end
endmodule

/* test/tb.sv */
// Self-checking testbench of the multiplexed display driver and segment decoder.
`timescale 1ns/10ps
`include "seg_display_params.svh"
`define CHK(nm, e, g) \
    begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb
    import seg_display_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int S = 4; // Short scan step so a rotation takes 48 clocks.
    localparam logic [7:0] SEG [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d,
        8'h07, 8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
    logic sys_clk;
    logic reset_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    display_out_type disp_out;
    logic cycle_complete_flag;
    logic operation_error;
    logic [2:0] mode_q; // Mode last written, tells the models the polarity.
    logic [15:0] shown1;
    logic [15:0] shown2;
    logic [31:0] rd_val;
    int error_cnt;
    int total_checks;

    multiplexed_bcd_display_driver #(.STEP_CYCLES(S)) i_dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disp_out(disp_out),
        .cycle_complete_flag(cycle_complete_flag), .operation_error(operation_error));
    display_latch_model i_grp1 (.sys_clk(sys_clk), .reset_n(reset_n),
        .data_nib(disp_out.group1), .strobe(disp_out.strobe), .data_neg(mode_q[1]),
        .strobe_neg(mode_q[0]), .shown_q(shown1));
    display_latch_model i_grp2 (.sys_clk(sys_clk), .reset_n(reset_n),
        .data_nib(disp_out.group2), .strobe(disp_out.strobe), .data_neg(mode_q[1]),
        .strobe_neg(mode_q[0]), .shown_q(shown2));

    // Free-running 125 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Single-cycle write; it takes effect at the second edge.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Single-cycle read; the data stand only in the following cycle.
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    // Four BCD digits of a decimal value, units in the low nibble.
    function automatic logic [15:0] bcd(input int v);
        return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Unmapped writes vanish and unmapped reads return zero.
    task automatic scen_regs();
        wr_reg(8'h40, 32'hffff_ffff);
        rd_reg(8'h40);
        `CHK("unmapped read", 32'h0, rd_val)
        rd_reg(`REG_CTRL);
        `CHK("ctrl reset", 32'h0, rd_val)
    endtask

    // Every nibble, with junk above it, over a destination whose high byte must stay.
    task automatic scen_decoder();
        wr_reg(`REG_SEG_DST, 32'h0000_a5c3);
        for (int n = 0; n < 16; n++)
        begin
            wr_reg(`REG_SEG_SRC, 32'h0000_fff0 | n);
            rd_reg(`REG_SEG_DST);
            `CHK("seg_dst", {16'h0, 8'ha5, SEG[n]}, rd_val)
        end
    endtask

    // All eight modes: idle level, first digit, first strobe and latched digits.
    task automatic scen_modes();
        logic [15:0] e1;
        logic [15:0] e2;
        for (int m = 0; m < 8; m++)
        begin
            e1 = bcd(1111 * m + 123);
            e2 = bcd(9876 - 1111 * m);
            mode_q = m[2:0];
            wr_reg(`REG_CTRL, {28'h0, m[2:0], 1'b0});
            cyc(2);
            #1;
            `CHK("idle strobe", {4{m[0]}}, disp_out.strobe)
            `CHK("idle data", 4'h0, disp_out.group1)
            wr_reg(`REG_VALUE1, 32'(1111 * m + 123));
            wr_reg(`REG_VALUE2, 32'(9876 - 1111 * m));
            wr_reg(`REG_CTRL, {28'h0, m[2:0], 1'b1});
            cyc(2);
            #1;
            `CHK("units data", e1[3:0] ^ {4{m[1]}}, disp_out.group1)
            `CHK("group2 data", m > 3 ? e2[3:0] ^ {4{m[1]}} : 4'h0, disp_out.group2)
            cyc(S);
            #1;
            `CHK("first strobe", m[0] ? 4'he : 4'h1, disp_out.strobe)
            cyc(12 * S);
            #1;
            `CHK("group1 shown", e1, shown1)
            if (m > 3)
                `CHK("group2 shown", e2, shown2)
        end
    endtask

    // Completion flag: one step high, once every twelve steps.
    task automatic scen_rotation();
        int k;
        int h;
        int l;
        wr_reg(`REG_CTRL, 32'h0);
        wr_reg(`REG_CTRL, 32'h1);
        k = 0;
        h = 0;
        l = 0;
        while (cycle_complete_flag !== 1'b1 && k <= 20 * S)
        begin
            cyc(1);
            #1;
            k++;
        end
        `CHK("first flag", 1'b1, k >= 12 * S && k <= 12 * S + 1)
        while (cycle_complete_flag === 1'b1 && h <= 20 * S)
        begin
            cyc(1);
            #1;
            h++;
        end
        `CHK("flag length", S, h)
        while (cycle_complete_flag !== 1'b1 && l <= 20 * S)
        begin
            cyc(1);
            #1;
            l++;
        end
        `CHK("flag gap", 11 * S, l)
        `CHK("step cycles", 1250000, `SCAN_STEP_CYCLES)
        if (k > 20 * S || h > 20 * S || l > 20 * S)
            report_and_stop();
    endtask

    // Out-of-range values; the second value counts only with two groups.
    task automatic scen_error();
        wr_reg(`REG_VALUE1, 32'd9999);
        wr_reg(`REG_VALUE2, 32'd10000);
        wr_reg(`REG_CTRL, 32'h1);
        wr_reg(`REG_STATUS, 32'h1);
        cyc(3);
        #1;
        `CHK("error one group", 1'b0, operation_error)
        wr_reg(`REG_CTRL, 32'h9);
        cyc(3);
        #1;
        `CHK("error two groups", 1'b1, operation_error)
        wr_reg(`REG_VALUE2, 32'd9999);
        wr_reg(`REG_STATUS, 32'h1);
        cyc(3);
        #1;
        `CHK("error at limit", 1'b0, operation_error)
        wr_reg(`REG_VALUE1, 32'd10000);
        rd_reg(`REG_STATUS);
        `CHK("error value1", 1'b1, rd_val[`STATUS_ERROR_BIT])
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mode_q = 3'h0;
        error_cnt = 0;
        total_checks = 0;
        cyc(9);
        #1;
        `CHK("reset outputs", 12'h000, disp_out)
        `CHK("reset flags", 2'b00, {cycle_complete_flag, operation_error})
        cyc(1);
        reset_n <= 1'b1;
        scen_regs();
        scen_decoder();
        scen_modes();
        scen_rotation();
        scen_error();
        report_and_stop();
    end
endmodule
